// file: iar_cfg.svh
// Constants for the interrupt identifier check and affinity router
`ifndef IAR_CFG_SVH
`define IAR_CFG_SVH
`define IAR_NPE          4
`define IAR_NSPI         4
`define IAR_AW           8
`define IAR_AFF_LVL_W    8
`define IAR_ID_W_SMALL   5'h10
`define IAR_ID_W_LARGE   5'h18
`define IAR_PE_IDW_TAB   {5'h18, 5'h10, 5'h10, 5'h10}
`define IAR_DIST_ID_W    5'h0E
`define IAR_ITS_ID_W     5'h0E
`define IAR_VID_W        5'h10
`define IAR_LPI_MIN_W    5'h0E
`define IAR_NOLPI_MIN_W  5'h05
`define IAR_NOLPI_MAX_W  5'h0A
`define IAR_LPI_SUPP     1'b1
`define IAR_A3V          1'b1
`define IAR_PARTICIPATION_DISABLE_SUPPORTED         1'b1
`define IAR_LOCAL_ERR    1'b1
`define IAR_VLOCAL_ERR   1'b1
`define IAR_ARE_PERM     1'b0
`define IAR_LPI_BASE     64'h0000_0000_0000_2000
`define IAR_SPECIAL_LO   64'h0000_0000_0000_03FC
`define IAR_SPECIAL_HI   64'h0000_0000_0000_03FF
`define IAR_PEND_CYC     3'h4
`define IAR_SGI_TL_MAX   8'h0F
`define IAR_PE_AFF_TAB   {32'h0000_0103, 32'h0000_0102, 32'h0000_0001, 32'h0000_0000}
// Byte offsets
`define IAR_OFF_CTRL     8'h00
`define IAR_OFF_TYPE     8'h04
`define IAR_OFF_PECTL    8'h08
`define IAR_OFF_SPICFG   8'h0C
`define IAR_OFF_ROUTE0   8'h10
`define IAR_OFF_SGIAFF   8'h20
`define IAR_OFF_SGIGEN   8'h24
`define IAR_OFF_SGIPEND  8'h28
`define IAR_OFF_CHKLO    8'h2C
`define IAR_OFF_CHKHI    8'h30
`define IAR_OFF_CHKCTL   8'h34
`define IAR_OFF_CHKSTAT  8'h38
// Control register fields
`define IAR_C_G0         0
`define IAR_C_G1NS       1
`define IAR_C_G1S        2
`define IAR_C_ARES       4
`define IAR_C_ARENS      5
`define IAR_C_SSM        6
`define IAR_C_WAKE       7
`define IAR_C_RWP        31
// Other fields
`define IAR_SGI_SRC_LSB  16
`define IAR_SGI_IRM      24
`define IAR_CHK_LPI      0
`define IAR_CHK_VIRT     1
`define IAR_CHK_PE_LSB   4
`endif

// file: iar_pkg.sv
// Types for the interrupt identifier check and affinity router
package iar_pkg;
  typedef enum logic [1:0] {
    IAR_OKAY   = 2'h0,
    IAR_SLVERR = 2'h2
  } iar_resp_t;
endpackage

// file: iar_route.sv
// Identifier check, affinity routing and AXI4-Lite control for the router
//
// Summary of operation
// - Each PE interface is 16 or 24 bits wide
// - One identifier width for distributor and redistributors
// - With LPIs: width 14 up to PE minimum
// - Without LPIs: width between 5 and 10
// - Translation unit width 14 up to distributor width
// - Set bits above interface width mean invalid
// - Disallowed LOCALITY_SPECIFIC_INTERRUPT identifier is invalid, may report
// - Special identifiers invalid, other in-width allowed identifiers valid
// - Virtual check uses virtual width and flag
// - Affinity is four 8-bit levels, 3 down to 0
// - Level-3 valid bit reports three or four levels
// - Separate route enables per security state
// - Permanent routing: enables read one, ignore writes
// - SPI mode bit: single target or 1-of-N
// - SOFTWARE_GENERATED_INTERRUPT mode 1: all PEs but the sender
// - SOFTWARE_GENERATED_INTERRUPT mode 0: upper levels match, level-0 bitmask
// - 1-of-N eligibility: awake, group on, participation
// - Write-pending flag shows group clears in flight
// - Identifiers 1020 to 1023 are special
// - Identifiers from 8192 are LPIs
`timescale 1ns/1ps
`include "iar_cfg.svh"

module iar_route (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write
  input  wire logic [`IAR_AW-1:0]        awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output iar_pkg::iar_resp_t             bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // AXI4-Lite read
  input  wire logic [`IAR_AW-1:0]        araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output iar_pkg::iar_resp_t             rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // Peripheral interrupt sources
  input  wire logic [`IAR_NSPI-1:0]      spi_in,
  // Per-PE interrupt requests
  output logic [`IAR_NPE-1:0]            pe_spi_irq,
  output logic [`IAR_NPE-1:0]            pe_sgi_irq,
  // Invalid identifier error
  output logic                           id_error_pulse
);
  import iar_pkg::*;
  localparam int NPE  = `IAR_NPE;
  localparam int NSPI = `IAR_NSPI;
  localparam int AL   = `IAR_AFF_LVL_W;
  localparam logic [NPE*32-1:0] PE_AFF = `IAR_PE_AFF_TAB;
  localparam logic [NPE*5-1:0]  PE_IDW = `IAR_PE_IDW_TAB;

  function automatic logic [4:0] min_pe_w();
    logic [4:0] m;
    m = PE_IDW[4:0];
    for (int k = 1; k < NPE; k++) begin
      if (PE_IDW[k*5 +: 5] < m) m = PE_IDW[k*5 +: 5];
    end
    return m;
  endfunction
  function automatic logic pe_w_legal();
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < NPE; k++) begin
      ok = ok & (PE_IDW[k*5 +: 5] == `IAR_ID_W_SMALL ||
                 PE_IDW[k*5 +: 5] == `IAR_ID_W_LARGE);
    end
    return ok;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction
  // Static width legality, visible in the type register
  localparam logic W_LPI_OK = (`IAR_DIST_ID_W >= `IAR_LPI_MIN_W) &&
                              (`IAR_DIST_ID_W <= min_pe_w());
  localparam logic W_NOLPI_OK = (`IAR_DIST_ID_W >= `IAR_NOLPI_MIN_W) &&
                                (`IAR_DIST_ID_W <= `IAR_NOLPI_MAX_W);
  localparam logic W_ITS_OK = (`IAR_ITS_ID_W >= `IAR_LPI_MIN_W) &&
                              (`IAR_ITS_ID_W <= `IAR_DIST_ID_W);
  localparam logic WIDTH_OK = pe_w_legal() & W_ITS_OK &
                              (`IAR_LPI_SUPP ? W_LPI_OK : W_NOLPI_OK);
  // Bus handshake state
  logic                  awready_reg;
  logic                  wready_reg;
  logic                  bvalid_reg;
  iar_resp_t             bresp_reg;
  logic                  arready_reg;
  logic                  rvalid_reg;
  logic [31:0]           rdata_reg;
  iar_resp_t             rresp_reg;
  logic [`IAR_AW-1:0]    waddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  // Software registers
  logic [31:0]           ctrl_reg;
  logic [31:0]           ctrl_next;
  logic [15:0]           pectl_reg;
  logic [7:0]            spicfg_reg;
  logic [NSPI*32-1:0]    route_reg;
  logic [23:0]           sgiaff_reg;
  logic [NPE-1:0]        sgi_pend_reg;
  logic [NPE-1:0]        sgi_pend_next;
  logic [31:0]           chklo_reg;
  logic [7:0]            chkctl_reg;
  logic [2:0]            chkstat_reg;
  logic [2:0]            pend_cnt_reg;
  logic [2:0]            pend_cnt_next;
  logic [2:0]            eff_grp_reg;
  logic [NPE-1:0]        spi_irq_reg;
  logic                  err_reg;
  // Write decode
  wire wr_go  = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire ar_hs  = arvalid & arready_reg;
  wire w_ctrl = wr_go & (waddr_reg == `IAR_OFF_CTRL);
  wire w_pec  = wr_go & (waddr_reg == `IAR_OFF_PECTL);
  wire w_spc  = wr_go & (waddr_reg == `IAR_OFF_SPICFG);
  wire w_rte  = wr_go & (waddr_reg[7:4] == `IAR_OFF_ROUTE0 >> 4);
  wire w_saff = wr_go & (waddr_reg == `IAR_OFF_SGIAFF);
  wire w_sgen = wr_go & (waddr_reg == `IAR_OFF_SGIGEN);
  wire w_spnd = wr_go & (waddr_reg == `IAR_OFF_SGIPEND);
  wire w_clo  = wr_go & (waddr_reg == `IAR_OFF_CHKLO);
  wire w_chi  = wr_go & (waddr_reg == `IAR_OFF_CHKHI);
  wire w_cctl = wr_go & (waddr_reg == `IAR_OFF_CHKCTL);
  wire w_ro   = (waddr_reg == `IAR_OFF_TYPE) | (waddr_reg == `IAR_OFF_CHKSTAT);
  wire w_map  = w_ctrl | w_pec | w_spc | w_rte | w_saff | w_sgen |
                w_spnd | w_clo | w_chi | w_cctl | (wr_go & w_ro);
  wire [31:0] wmerged_ctrl = merge(ctrl_reg, wdata_reg, wstrb_reg);
  wire [31:0] wmerged_pec  = merge({16'h0000, pectl_reg}, wdata_reg, wstrb_reg);
  // Control fields
  wire are_s    = ctrl_reg[`IAR_C_ARES];
  wire nonsecure_affinity_route_enable   = ctrl_reg[`IAR_C_ARENS];
  wire wake_f   = ctrl_reg[`IAR_C_WAKE];
  wire [NPE-1:0] asleep   = pectl_reg[3:0];
  wire [NPE-1:0] g0_dis   = pectl_reg[7:4];
  wire [NPE-1:0] g1ns_dis = pectl_reg[11:8];
  wire grp_clear = |(ctrl_reg[2:0] & ~wmerged_ctrl[2:0]);
  always_comb begin
    ctrl_next = {24'h000000, wmerged_ctrl[7:0]};
    ctrl_next[3] = 1'b0;
    if (`IAR_ARE_PERM) begin
      ctrl_next[`IAR_C_ARES]  = 1'b1;
      ctrl_next[`IAR_C_ARENS] = 1'b1;
    end
  end
  // Group clears take effect after a settle time
  always_comb begin
    pend_cnt_next = pend_cnt_reg;
    if (w_ctrl && grp_clear) begin
      pend_cnt_next = `IAR_PEND_CYC;
    end else if (pend_cnt_reg != 3'h0) begin
      pend_cnt_next = pend_cnt_reg - 3'h1;
    end
  end
  wire write_pending_flag = (pend_cnt_reg != 3'h0);
  // Identifier check on the 64-bit value being written
  wire [63:0] chk_data  = {wdata_reg, chklo_reg};
  wire        chk_virt  = chkctl_reg[`IAR_CHK_VIRT];
  wire        chk_lpi   = chkctl_reg[`IAR_CHK_LPI];
  wire [1:0]  chk_pe    = chkctl_reg[`IAR_CHK_PE_LSB +: 2];
  wire [4:0]  chk_w     = chk_virt ? `IAR_VID_W : PE_IDW[chk_pe*5 +: 5];
  wire [63:0] chk_keep  = (64'h1 << chk_w) - 64'h1;
  wire        hi_bad    = |(chk_data & ~chk_keep);
  wire        is_lpi    = chk_data >= `IAR_LPI_BASE;
  wire        lpi_bad   = ~chk_lpi & is_lpi;
  wire        is_spec   = (chk_data >= `IAR_SPECIAL_LO) &
                          (chk_data <= `IAR_SPECIAL_HI);
  wire        chk_valid = ~hi_bad & ~lpi_bad & ~is_spec;
  wire        err_en    = chk_virt ? `IAR_VLOCAL_ERR : `IAR_LOCAL_ERR;
  wire        chk_err   = w_chi & err_en & (hi_bad | lpi_bad);
  // SPI routing, one slice per interrupt
  logic [NPE-1:0] spi_tgt [NSPI];
  genvar gi;
  generate
    for (gi = 0; gi < NSPI; gi++) begin : g_spi
      wire [31:0]    aff   = route_reg[gi*32 +: 32];
      wire           mode  = spicfg_reg[gi];
      wire           grp1  = spicfg_reg[NSPI+gi];
      wire           grpon = grp1 ? eff_grp_reg[`IAR_C_G1NS] : eff_grp_reg[`IAR_C_G0];
      wire           rton  = grp1 ? nonsecure_affinity_route_enable : are_s;
      wire [NPE-1:0] pdis  = grp1 ? g1ns_dis : g0_dis;
      logic [NPE-1:0] match;
      logic [NPE-1:0] elig;
      for (genvar gj = 0; gj < NPE; gj++) begin : g_pe
        wire [31:0] pa = PE_AFF[gj*32 +: 32];
        // Without level 3 the top field is fixed at zero
        wire top_ok = `IAR_A3V ? (aff[3*AL +: AL] == pa[3*AL +: AL])
                               : (aff[3*AL +: AL] == 8'h00);
        assign match[gj] = top_ok & (aff[3*AL-1:0] == pa[3*AL-1:0]);
        assign elig[gj] = (~asleep[gj] | wake_f) & grpon &
                          ~(`IAR_PARTICIPATION_DISABLE_SUPPORTED & pdis[gj]);
      end
      wire [NPE-1:0] pick = elig & (~elig + {{(NPE-1){1'b0}}, 1'b1});
      assign spi_tgt[gi] = (rton & spi_in[gi]) ? (mode ? pick : match)
                                               : {NPE{1'b0}};
    end
  endgenerate
  // SOFTWARE_GENERATED_INTERRUPT targets
  logic [NPE-1:0] sgi_tgt;
  logic [NPE-1:0] spi_col;
  wire [15:0] sgi_tl  = wdata_reg[15:0];
  wire [1:0]  sgi_src = wdata_reg[`IAR_SGI_SRC_LSB +: 2];
  wire        sgi_irm = wdata_reg[`IAR_SGI_IRM];
  generate
    for (gi = 0; gi < NPE; gi++) begin : g_sgi
      wire [31:0] pa  = PE_AFF[gi*32 +: 32];
      wire [7:0]  a0  = pa[AL-1:0];
      wire        up  = (pa[31:AL] == sgiaff_reg) & (a0 <= `IAR_SGI_TL_MAX);
      wire        tl  = up & sgi_tl[a0[3:0]];
      wire        all = (sgi_src != 2'(gi));
      assign sgi_tgt[gi] = w_sgen & (sgi_irm ? all : tl);
      logic acc;
      always_comb begin
        acc = 1'b0;
        for (int k = 0; k < NSPI; k++) begin
          acc = acc | spi_tgt[k][gi];
        end
      end
      assign spi_col[gi] = acc;
    end
  endgenerate
  // Set wins over a clear in the same cycle
  wire [NPE-1:0] sgi_clr = w_spnd ? wdata_reg[NPE-1:0] : {NPE{1'b0}};
  assign sgi_pend_next = (sgi_pend_reg & ~sgi_clr) | sgi_tgt;
  // Read mux
  logic [31:0] rd_mux;
  logic        rd_hit;
  wire  [31:0] type_val = {3'h0, `IAR_VID_W, 3'h0, `IAR_DIST_ID_W,
                           3'h0, min_pe_w(), 4'h0, WIDTH_OK,
                           `IAR_LOCAL_ERR, `IAR_PARTICIPATION_DISABLE_SUPPORTED, `IAR_A3V};
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (araddr)
      `IAR_OFF_CTRL:    rd_mux = {write_pending_flag, ctrl_reg[30:0]};
      `IAR_OFF_TYPE:    rd_mux = type_val;
      `IAR_OFF_PECTL:   rd_mux = {16'h0000, pectl_reg};
      `IAR_OFF_SPICFG:  rd_mux = {24'h000000, spicfg_reg};
      `IAR_OFF_SGIAFF:  rd_mux = {8'h00, sgiaff_reg};
      `IAR_OFF_SGIGEN:  rd_mux = 32'h0000_0000;
      `IAR_OFF_SGIPEND: rd_mux = {{(32-NPE){1'b0}}, sgi_pend_reg};
      `IAR_OFF_CHKLO:   rd_mux = chklo_reg;
      `IAR_OFF_CHKHI:   rd_mux = 32'h0000_0000;
      `IAR_OFF_CHKCTL:  rd_mux = {24'h000000, chkctl_reg};
      `IAR_OFF_CHKSTAT: rd_mux = {29'h0, chkstat_reg};
      default: begin
        if (araddr[7:4] == `IAR_OFF_ROUTE0 >> 4 && araddr[1:0] == 2'h0) begin
          rd_mux = route_reg[araddr[3:2]*32 +: 32];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end
  // Write channel handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= IAR_OKAY;
      waddr_reg   <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        waddr_reg   <= awaddr;
      end else if (bvalid_reg && bready) begin
        awready_reg <= 1'b1;
      end
      if (wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end else if (bvalid_reg && bready) begin
        wready_reg <= 1'b1;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= w_map ? IAR_OKAY : IAR_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  // Read channel handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= IAR_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_hit ? IAR_OKAY : IAR_SLVERR;
    end else if (rvalid_reg && rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end
  // Register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg   <= {24'h000000, 2'h0, `IAR_ARE_PERM, `IAR_ARE_PERM, 4'h0};
      pectl_reg  <= 16'h0000;
      spicfg_reg <= 8'h00;
      route_reg  <= '0;
      sgiaff_reg <= 24'h000000;
      chklo_reg  <= 32'h0000_0000;
      chkctl_reg <= 8'h00;
    end else begin
      if (w_ctrl) begin
        ctrl_reg <= ctrl_next;
      end
      if (w_pec) begin
        pectl_reg <= wmerged_pec[15:0];
      end
      if (w_spc) begin
        spicfg_reg <= wdata_reg[7:0];
      end
      if (w_rte) begin
        route_reg[waddr_reg[3:2]*32 +: 32] <=
          merge(route_reg[waddr_reg[3:2]*32 +: 32], wdata_reg, wstrb_reg);
      end
      if (w_saff) begin
        sgiaff_reg <= wdata_reg[23:0];
      end
      if (w_clo) begin
        chklo_reg <= wdata_reg;
      end
      if (w_cctl) begin
        chkctl_reg <= wdata_reg[7:0];
      end
    end
  end
  // Router state and outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_cnt_reg <= 3'h0;
      eff_grp_reg  <= 3'h0;
      sgi_pend_reg <= {NPE{1'b0}};
      spi_irq_reg  <= {NPE{1'b0}};
      chkstat_reg  <= 3'h0;
      err_reg      <= 1'b0;
    end else begin
      pend_cnt_reg <= pend_cnt_next;
      if (pend_cnt_next == 3'h0) begin
        eff_grp_reg <= ctrl_reg[2:0];
      end
      sgi_pend_reg <= sgi_pend_next;
      spi_irq_reg  <= spi_col;
      err_reg      <= chk_err;
      if (w_chi) begin
        chkstat_reg <= {1'b1, err_en & (hi_bad | lpi_bad), chk_valid};
      end
    end
  end
  assign awready        = awready_reg;
  assign wready         = wready_reg;
  assign bvalid         = bvalid_reg;
  assign bresp          = bresp_reg;
  assign arready        = arready_reg;
  assign rvalid         = rvalid_reg;
  assign rdata          = rdata_reg;
  assign rresp          = rresp_reg;
  assign pe_spi_irq     = spi_irq_reg;
  assign pe_sgi_irq     = sgi_pend_reg;
  assign id_error_pulse = err_reg;
endmodule

// file: iar_route_monitor.sv
// Bus and routing assertions for the identifier check and router
`timescale 1ns/1ps
`include "iar_cfg.svh"
module iar_route_monitor (
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Register bus
  input wire logic                     awvalid,
  input wire logic                     awready,
  input wire logic                     wvalid,
  input wire logic                     wready,
  input wire iar_pkg::iar_resp_t       bresp,
  input wire logic                     bvalid,
  input wire logic                     bready,
  input wire logic                     arvalid,
  input wire logic                     arready,
  input wire logic [31:0]              rdata,
  input wire logic                     rvalid,
  input wire logic                     rready,
  // Interrupts
  input wire logic [`IAR_NSPI-1:0]     spi_in,
  input wire logic [`IAR_NPE-1:0]      pe_spi_irq,
  input wire logic [`IAR_NPE-1:0]      pe_sgi_irq,
  input wire logic                     id_error_pulse
);
  import iar_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  busy_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("new write taken while answer open");
  reset_idle_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && awready && arready
    && pe_spi_irq == '0 && pe_sgi_irq == '0 && !id_error_pulse)
    else $error("outputs not idle after reset");
  err_single_a: assert property (id_error_pulse |=> !id_error_pulse)
    else $error("error pulse longer than one cycle");
  spi_quiet_a: assert property (spi_in == '0 |=> pe_spi_irq == '0)
    else $error("peripheral request without source");
  sgi_cause_a: assert property ((pe_sgi_irq & ~$past(pe_sgi_irq)) != '0 |-> bvalid || $past(bvalid))
    else $error("software interrupt without write");
endmodule

// file: iar_pe_model.sv
// Processing-element side: records the requests it is handed
`timescale 1ns/1ps
`include "iar_cfg.svh"
module iar_pe_model (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Requests from the router
  input  wire logic [`IAR_NPE-1:0]     pe_spi_irq,
  input  wire logic [`IAR_NPE-1:0]     pe_sgi_irq,
  // Record of delivered requests
  output logic      [`IAR_NPE-1:0]     spi_seen,
  output logic      [`IAR_NPE-1:0]     sgi_seen
);
  // Node affinities keep level 0 inside the target mask range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spi_seen <= '0;
      sgi_seen <= '0;
    end else begin
      spi_seen <= spi_seen | pe_spi_irq;
      sgi_seen <= sgi_seen | pe_sgi_irq;
    end
  end
endmodule

// file: iar_route_test.sv
// Self-checking bench for the identifier check and affinity router
`timescale 1ns/1ps
`include "iar_cfg.svh"
module iar_route_test;
  import iar_pkg::*;
  logic                  aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, id_error_pulse;
  logic [`IAR_AW-1:0]    awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  iar_resp_t             bresp, rresp;
  logic [`IAR_NSPI-1:0]  spi_in;
  logic [`IAR_NPE-1:0]   pe_spi_irq, pe_sgi_irq, spi_seen, sgi_seen;
  int                    n_errors, compares, n_pulse, cyc;

  iar_route dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .spi_in(spi_in), .pe_spi_irq(pe_spi_irq), .pe_sgi_irq(pe_sgi_irq),
    .id_error_pulse(id_error_pulse));
  iar_pe_model pe_u (.aclk(aclk), .aresetn(aresetn), .pe_spi_irq(pe_spi_irq),
    .pe_sgi_irq(pe_sgi_irq), .spi_seen(spi_seen), .sgi_seen(sgi_seen));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (id_error_pulse === 1'b1) n_pulse++;
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize;
    end
  end

  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input iar_resp_t er = IAR_OKAY);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    chk(bresp, er, "write response");
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output iar_resp_t r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic t_regs;
    logic [31:0] d;
    iar_resp_t r;
    wr(`IAR_OFF_TYPE, 32'h0000_0000);
    rd(`IAR_OFF_TYPE, d, r);
    chk(d[3:0], 4'hF, "type flags");
    chk(d[12:8], `IAR_ID_W_SMALL, "interface width");
    chk(d[20:16], `IAR_DIST_ID_W, "common width");
    chk(d[20:16] >= 5'h0E && d[20:16] <= d[12:8], 1'b1, "width bounds");
    chk(d[28:24], `IAR_VID_W, "virtual width");
    rd(8'h40, d, r);
    chk(r, IAR_SLVERR, "unmapped read");
    chk(d, 32'h0000_0000, "unmapped data");
    wr(8'h44, 32'hFFFF_FFFF, IAR_SLVERR);
    $display("test registers done");
  endtask

  task automatic idc(input logic [7:0] ctl, input logic [63:0] v, input logic [1:0] e);
    logic [31:0] d;
    iar_resp_t r;
    int p;
    wr(`IAR_OFF_CHKCTL, {24'h00_0000, ctl});
    wr(`IAR_OFF_CHKLO, v[31:0]);
    p = n_pulse;
    wr(`IAR_OFF_CHKHI, v[63:32]);
    rd(`IAR_OFF_CHKSTAT, d, r);
    chk(d[2:0], {1'b1, e}, "check status");
    chk(n_pulse - p, e[1], "error pulses");
  endtask

  task automatic t_ids;
    idc(8'h01, 64'h0000_0000_0000_0020, 2'b01);
    idc(8'h01, 64'h0000_0000_0000_03FB, 2'b01);
    idc(8'h01, 64'h0000_0000_0000_03FC, 2'b00);
    idc(8'h01, 64'h0000_0000_0000_03FF, 2'b00);
    idc(8'h01, 64'h0000_0000_0001_0000, 2'b10);
    idc(8'h31, 64'h0000_0000_0001_0000, 2'b01);
    idc(8'h31, 64'h8000_0000_0000_0000, 2'b10);
    idc(8'h00, 64'h0000_0000_0000_2000, 2'b10);
    idc(8'h00, 64'h0000_0000_0000_1FFF, 2'b01);
    idc(8'h33, 64'h0000_0000_0001_0000, 2'b10);
    idc(8'h03, 64'h0000_0000_0000_03FD, 2'b00);
    $display("test identifier check done");
  endtask

  task automatic t_spi;
    logic [31:0] d;
    iar_resp_t r;
    wr(`IAR_OFF_SPICFG, 32'h0000_0000);
    wr(`IAR_OFF_ROUTE0, 32'h0000_0102);
    wr(`IAR_OFF_CTRL, 32'h0000_0003);
    spi_in <= 4'h1;
    settle(3);
    chk(pe_spi_irq, 4'h0, "routing still off");
    // Groups off and settled before routing goes on
    wr(`IAR_OFF_CTRL, 32'h0000_0000);
    repeat (20) begin
      rd(`IAR_OFF_CTRL, d, r);
      if (d[31] === 1'b0) break;
    end
    chk(d[31], 1'b0, "pending flag clears");
    wr(`IAR_OFF_CTRL, 32'h0000_0030);
    wr(`IAR_OFF_CTRL, 32'h0000_0033);
    rd(`IAR_OFF_CTRL, d, r);
    chk(d[5:4], 2'b11, "route enables set");
    settle(3);
    chk(pe_spi_irq, 4'h4, "single target");
    wr(`IAR_OFF_SPICFG, 32'h0000_0001);
    wr(`IAR_OFF_PECTL, 32'h0000_0001);
    settle(3);
    chk(pe_spi_irq, 4'h2, "sleeping node skipped");
    wr(`IAR_OFF_PECTL, 32'h0000_0021);
    settle(3);
    chk(pe_spi_irq, 4'h4, "opted-out node skipped");
    wr(`IAR_OFF_CTRL, 32'h0000_00B3);
    settle(3);
    chk(pe_spi_irq, 4'h1, "wake flag admits sleeper");
    spi_in <= 4'h0;
    settle(2);
    chk(pe_spi_irq, 4'h0, "source dropped");
    chk(spi_seen, 4'h7, "nodes reached");
    $display("test shared routing done");
  endtask

  task automatic t_sgi;
    wr(`IAR_OFF_SGIAFF, 32'h0000_0001);
    wr(`IAR_OFF_SGIGEN, 32'h0000_000C);
    settle(2);
    chk(pe_sgi_irq, 4'hC, "target list");
    wr(`IAR_OFF_SGIPEND, 32'h0000_000F);
    settle(2);
    chk(pe_sgi_irq, 4'h0, "pending cleared");
    wr(`IAR_OFF_SGIGEN, 32'h0101_FFFF);
    settle(2);
    chk(pe_sgi_irq, 4'hD, "all but sender");
    wr(`IAR_OFF_SGIPEND, 32'h0000_000F);
    wr(`IAR_OFF_SGIAFF, 32'h0000_0000);
    wr(`IAR_OFF_SGIGEN, 32'h0000_FFFE);
    settle(2);
    chk(pe_sgi_irq, 4'h2, "upper levels match");
    chk(sgi_seen, 4'hF, "nodes reached");
    $display("test software interrupts done");
  endtask

  task automatic t_ssm;
    logic [31:0] d;
    iar_resp_t r;
    aresetn <= 1'b0;
    settle(2);
    chk(pe_sgi_irq, 4'h0, "reset clears pending");
    aresetn <= 1'b1;
    rd(`IAR_OFF_CTRL, d, r);
    chk(d, {26'h0, `IAR_ARE_PERM, `IAR_ARE_PERM, 4'h0}, "control after reset");
    wr(`IAR_OFF_CTRL, 32'h0000_0040);
    wr(`IAR_OFF_CTRL, 32'h0000_0070);
    wr(`IAR_OFF_CTRL, 32'h0000_0072);
    wr(`IAR_OFF_SPICFG, 32'h0000_0011);
    wr(`IAR_OFF_PECTL, 32'h0000_0100);
    wstrb <= 4'h2;
    wr(`IAR_OFF_ROUTE0 + 8'h04, 32'hFFFF_FFFF);
    wstrb <= 4'hF;
    rd(`IAR_OFF_ROUTE0 + 8'h04, d, r);
    chk(d, 32'h0000_FF00, "byte lanes");
    spi_in <= 4'h1;
    settle(3);
    chk(pe_spi_irq, 4'h2, "group 1 eligibility");
    spi_in <= 4'h0;
    settle(2);
    chk(spi_seen, 4'h2, "nodes reached after reset");
    $display("test single security mode done");
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr  = '0;
    awvalid = 1'b0;
    wdata   = '0;
    wstrb   = 4'hF;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = '0;
    arvalid = 1'b0;
    rready  = 1'b0;
    spi_in  = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_ids;
    t_spi;
    t_sgi;
    t_ssm;
    summarize;
  end
endmodule

bind iar_route iar_route_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .spi_in(spi_in), .pe_spi_irq(pe_spi_irq), .pe_sgi_irq(pe_sgi_irq),
  .id_error_pulse(id_error_pulse));
